/* File: pkg/eeprom_access_pkg.sv */
// constants and carrier types for the data eeprom access controller
// assumes a single cpu clock domain and a byte-wide internal memory bus
package eeprom_access_pkg;
  localparam logic [15:0] CSR_ADDR       = 16'h0030;
  localparam logic [15:0] EE_BASE        = 16'h1000;
  localparam int          EE_BYTES       = 128;
  localparam int          ROW_BYTES      = 32;
  localparam int          LATCH_BIT      = 1;
  localparam int          PROG_BIT       = 0;
  localparam logic [7:0]  CSR_RESET      = 8'h00;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam int          PROG_TIME_NS   = 40000;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          PROG_CYCLES    = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int          ERASE_CYCLES   = PROG_CYCLES / 2;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ERASE = 4'h2,
    ST_WRITE = 4'h4,
    ST_WIPE  = 4'h8
  } ee_state_t;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic        rd;
    logic        fetch;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cpu_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rdata_oe;
  } cpu_rsp_t;
endpackage : eeprom_access_pkg

/* File: hw/data_eeprom_access_controller.sv */
// data eeprom access controller: array, row latches and control/status
// assumes cpu bus inputs synchronous to clk_sys; rst is synchronous
// Functional notes
// - latch mode clear: non-fetch reads return addressed byte within one cycle
// - latch mode, no program: writes land in 32 byte latches
// - setting program bit programs all captured latches at once
// - row comes from upper bits of last latched write address
// - end of programming clears program and latch bits together
// - repeated writes to a latch program the and of the values
// - latches clear only at reset, programming end, halt or latch bit falling
// - latch contents have no read path
// - wait request: idle enters wait now, busy finishes first
// - halt stops at once, abandoning any programming
// - reads in latch mode leave the data bus undriven
// - writes with latch mode clear are ignored
// - protection blocks external read-out and rewriting
// - removing protection first erases the whole eeprom
// - control/status bits 7 to 2 always read zero
// - bit 1 latch mode; software clear only while program is zero
// - bit 0 starts programming, reads one until done
// - cycle timed internally with chained erase then program
`timescale 1ns/1ns
`default_nettype none
module data_eeprom_access_controller
  import eeprom_access_pkg::*;
#(
  parameter int PROG_LEN  = PROG_CYCLES,
  parameter int ERASE_LEN = ERASE_CYCLES
) (
  input  wire logic     clk_sys,
  input  wire logic     rst,
  input  wire cpu_req_t cpu_req,
  input  wire logic     ext_access,
  input  wire logic     protect_on,
  input  wire logic     unprotect_req,
  input  wire logic     wait_req,
  input  wire logic     halt_req,
  output var  cpu_rsp_t cpu_rsp,
  output var  logic     wait_ack,
  output var  logic     halted,
  output var  logic     busy
);
  localparam int AW = $clog2(EE_BYTES);
  localparam int LW = $clog2(ROW_BYTES);
  localparam int CW = $clog2(PROG_LEN + ERASE_LEN + EE_BYTES + 2);

  typedef struct packed {
    ee_state_t             st;
    logic                  lat;
    logic                  program_bit;
    logic [ROW_BYTES-1:0]  used;
    logic [AW-LW-1:0]      row;
    logic [CW-1:0]         cnt;
    logic                  wait_ack;
    logic                  halted;
    cpu_rsp_t              rsp;
    logic [CW-1:0]         blen;
  } regs_t;

  regs_t      r_ff;
  regs_t      nxt_r;
  logic [7:0] latch_ff [ROW_BYTES];
  logic [7:0] mem_ff   [EE_BYTES];

  function automatic logic in_array(input logic [15:0] a);
    in_array = (a >= EE_BASE) && (a < EE_BASE + 16'(EE_BYTES));
  endfunction : in_array

  logic          ee_hit;
  logic          csr_hit;
  logic [AW-1:0] ee_idx;
  logic          lat_wr;
  logic          lat_fall;
  logic          cycle_end;
  logic          wipe_start;

  assign ee_hit     = cpu_req.sel && in_array(cpu_req.addr);
  assign csr_hit    = cpu_req.sel && (cpu_req.addr == CSR_ADDR);
  assign ee_idx     = cpu_req.addr[AW-1:0];
  assign lat_wr     = ee_hit && cpu_req.wr && r_ff.lat && !r_ff.program_bit &&
                      !protect_on && !r_ff.halted;
  assign cycle_end  = (r_ff.st == ST_WRITE) && (r_ff.cnt == '0);
  assign wipe_start = unprotect_req && protect_on && !r_ff.halted;
  assign lat_fall   = r_ff.lat && !nxt_r.lat;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.rsp.rdata_oe = 1'b0;
    nxt_r.rsp.rdata    = 8'h00;
    if (ee_hit && cpu_req.rd && !cpu_req.fetch && !r_ff.lat &&
        !(protect_on && ext_access)) begin
      nxt_r.rsp.rdata_oe = 1'b1;
      nxt_r.rsp.rdata    = mem_ff[ee_idx];
    end else if (csr_hit && cpu_req.rd) begin
      nxt_r.rsp.rdata_oe = 1'b1;
      nxt_r.rsp.rdata    = {6'h00, r_ff.lat, r_ff.program_bit};
    end
    if (lat_wr) begin
      nxt_r.used[ee_idx[LW-1:0]] = 1'b1;
      nxt_r.row = ee_idx[AW-1:LW];
    end
    if (csr_hit && cpu_req.wr && !r_ff.halted) begin
      if (cpu_req.wdata[LATCH_BIT])
        nxt_r.lat = 1'b1;
      else if (!r_ff.program_bit && !cpu_req.wdata[PROG_BIT])
        nxt_r.lat = 1'b0;
      if (cpu_req.wdata[PROG_BIT] && r_ff.lat && r_ff.st == ST_IDLE &&
          !protect_on) begin
        nxt_r.program_bit = 1'b1;
        nxt_r.st  = ST_ERASE;
        nxt_r.cnt = CW'(ERASE_LEN - 1);
      end
    end
    case (r_ff.st)
      ST_ERASE: begin
        if (r_ff.cnt == '0) begin
          nxt_r.st  = ST_WRITE;
          nxt_r.cnt = CW'(PROG_LEN - 1);
        end else begin
          nxt_r.cnt = r_ff.cnt - 1'b1;
        end
      end
      ST_WRITE: begin
        if (cycle_end) begin
          nxt_r.st   = ST_IDLE;
          nxt_r.program_bit  = 1'b0;
          nxt_r.lat  = 1'b0;
          nxt_r.used = '0;
        end else begin
          nxt_r.cnt = r_ff.cnt - 1'b1;
        end
      end
      ST_WIPE: begin
        if (r_ff.cnt == CW'(EE_BYTES - 1))
          nxt_r.st = ST_IDLE;
        else
          nxt_r.cnt = r_ff.cnt + 1'b1;
      end
      default: begin
      end
    endcase
    if (wipe_start && r_ff.st == ST_IDLE) begin
      nxt_r.st  = ST_WIPE;
      nxt_r.cnt = '0;
    end
    if (!nxt_r.lat)
      nxt_r.used = '0;
    nxt_r.blen = r_ff.program_bit ? r_ff.blen + 1'b1 : '0;
    nxt_r.wait_ack = wait_req && (nxt_r.st == ST_IDLE);
    if (halt_req) begin
      nxt_r.st     = ST_IDLE;
      nxt_r.program_bit    = 1'b0;
      nxt_r.halted = 1'b1;
    end else begin
      nxt_r.halted = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r_ff.st       <= ST_IDLE;
      r_ff.lat      <= CSR_RESET[LATCH_BIT];
      r_ff.program_bit      <= CSR_RESET[PROG_BIT];
      r_ff.used     <= '0;
      r_ff.row      <= '0;
      r_ff.cnt      <= '0;
      r_ff.wait_ack <= 1'b0;
      r_ff.halted   <= 1'b0;
      r_ff.rsp      <= '0;
      r_ff.blen     <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < ROW_BYTES; i++) begin
      if (rst || cycle_end || lat_fall || r_ff.halted)
        latch_ff[i] <= ERASED_BYTE;
      else if (lat_wr && ee_idx[LW-1:0] == LW'(i))
        latch_ff[i] <= latch_ff[i] & cpu_req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < EE_BYTES; i++) begin
      if (r_ff.st == ST_WIPE && r_ff.cnt == CW'(i))
        mem_ff[i] <= ERASED_BYTE;
      else if (cycle_end && !halt_req && r_ff.row == (AW-LW)'(i / ROW_BYTES)
               && r_ff.used[i % ROW_BYTES])
        mem_ff[i] <= latch_ff[i % ROW_BYTES];
    end
  end

  assign cpu_rsp  = r_ff.rsp;
  assign wait_ack = r_ff.wait_ack;
  assign halted   = r_ff.halted;
  assign busy     = r_ff.program_bit;

  AST_CSR_ZERO: assert property (
    @(posedge clk_sys) disable iff (rst)
    (csr_hit && cpu_req.rd)
    |=> cpu_rsp.rdata[7:2] == 6'h00)
    else $error("reserved bits not zero");

  AST_LAT_NO_DRIVE: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ee_hit && cpu_req.rd && r_ff.lat)
    |=> !cpu_rsp.rdata_oe)
    else $error("bus driven in latch mode");

  AST_READ_ONE: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ee_hit && cpu_req.rd && !cpu_req.fetch && !r_ff.lat && !ext_access)
    |=> cpu_rsp.rdata_oe)
    else $error("array read not answered");

  AST_RD_DATA: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ee_hit && cpu_req.rd && !cpu_req.fetch && !r_ff.lat && !ext_access)
    |=> cpu_rsp.rdata == $past(mem_ff[ee_idx]))
    else $error("array read data wrong");

  AST_NO_FETCH: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ee_hit && cpu_req.rd && cpu_req.fetch)
    |=> !cpu_rsp.rdata_oe)
    else $error("fetch answered from array");

  AST_END_CLEARS: assert property (
    @(posedge clk_sys) disable iff (rst)
    (cycle_end && !halt_req)
    |=> !r_ff.program_bit && !r_ff.lat)
    else $error("end did not clear bits");

  AST_PGM_HOLD: assert property (
    @(posedge clk_sys) disable iff (rst)
    ($rose(r_ff.program_bit) && !halt_req)
    |-> r_ff.st == ST_ERASE)
    else $error("program bit without cycle");

  AST_PGM_START: assert property (
    @(posedge clk_sys) disable iff (rst)
    (csr_hit && cpu_req.wr && cpu_req.wdata[PROG_BIT] && r_ff.lat &&
     r_ff.st == ST_IDLE && !protect_on && !r_ff.halted && !halt_req)
    |=> r_ff.program_bit && r_ff.st == ST_ERASE)
    else $error("program start not taken");

  AST_CYCLE_LEN: assert property (
    @(posedge clk_sys) disable iff (rst)
    (cycle_end && !halt_req)
    |-> r_ff.blen == CW'(PROG_LEN + ERASE_LEN - 1))
    else $error("programming cycle length wrong");

  AST_LAT_CAPTURE: assert property (
    @(posedge clk_sys) disable iff (rst)
    lat_wr
    |=> r_ff.used[$past(ee_idx[LW-1:0])])
    else $error("latched write not recorded");

  AST_ROW_TRACK: assert property (
    @(posedge clk_sys) disable iff (rst)
    lat_wr
    |=> r_ff.row == $past(ee_idx[AW-1:LW]))
    else $error("row not taken from last write");

  AST_AND_MERGE: assert property (
    @(posedge clk_sys) disable iff (rst)
    lat_wr |=> latch_ff[$past(ee_idx[LW-1:0])] ==
      ($past(latch_ff[ee_idx[LW-1:0]]) & $past(cpu_req.wdata)))
    else $error("repeated write not anded");

  AST_LATCH_CLEAR: assert property (
    @(posedge clk_sys) disable iff (rst)
    (cycle_end || lat_fall)
    |=> r_ff.used == '0 && latch_ff[0] == ERASED_BYTE)
    else $error("latches not cleared");

  AST_NO_LAT_WR: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ee_hit && cpu_req.wr && !r_ff.lat)
    |=> $stable(r_ff.used))
    else $error("write latched in read mode");

  AST_NO_PROT_WR: assert property (
    @(posedge clk_sys) disable iff (rst)
    (protect_on && ee_hit && cpu_req.wr && !cycle_end)
    |=> $stable(r_ff.used))
    else $error("write latched while protected");

  AST_WIPE_RUN: assert property (
    @(posedge clk_sys) disable iff (rst)
    (wipe_start && r_ff.st == ST_IDLE && !halt_req)
    |=> r_ff.st == ST_WIPE)
    else $error("unprotect did not start wipe");

  AST_SW_CLR: assert property (
    @(posedge clk_sys) disable iff (rst)
    (csr_hit && cpu_req.wr && !cpu_req.wdata[LATCH_BIT] && r_ff.program_bit &&
     !halt_req && !cycle_end)
    |=> r_ff.lat)
    else $error("latch bit cleared while programming");

  AST_WAIT_IDLE: assert property (
    @(posedge clk_sys) disable iff (rst)
    (wait_req && r_ff.st == ST_IDLE && !csr_hit && !wipe_start)
    |=> wait_ack)
    else $error("idle wait not entered");

  AST_WAIT_BUSY: assert property (
    @(posedge clk_sys) disable iff (rst)
    (r_ff.st != ST_IDLE)
    |-> !wait_ack)
    else $error("wait entered while busy");

  AST_HALT_STOP: assert property (
    @(posedge clk_sys) disable iff (rst)
    halt_req
    |=> r_ff.st == ST_IDLE && !r_ff.program_bit)
    else $error("halt did not stop");
endmodule : data_eeprom_access_controller
`default_nettype wire

/* File: verification/cpu_bus_model.sv */
// cpu core model: one byte read or write per xfer call
// assumes the bench calls xfer; signals change at the falling edge
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model
  import eeprom_access_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire cpu_rsp_t rsp,
  output var  cpu_req_t req
);
  initial req = '0;
  task automatic xfer(input logic w, input logic f, input logic [15:0] a,
                      input logic [7:0] d, output cpu_rsp_t r);
    @(negedge clk_sys);
    // opcode fetch only when the bench asks for it
    req = '{sel: 1'b1, wr: w, rd: !w, fetch: f, addr: a, wdata: d};
    @(negedge clk_sys);
    r = rsp;
    // released bus shows inverted address and data
    req = '{sel: 1'b0, wr: 1'b0, rd: 1'b0, fetch: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
endmodule : cpu_bus_model
`default_nettype wire

/* File: verification/tb_top.sv */
// bench for the data eeprom access controller
// assumes cpu_bus_model as bus partner; short programming cycle
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import eeprom_access_pkg::*;
  ;
  logic     clk_sys = 1'b0;
  logic     rst = 1'b1;
  logic     ext_access = 1'b0;
  logic     protect_on = 1'b0;
  logic     unprotect_req = 1'b0;
  logic     wait_req = 1'b0;
  logic     halt_req = 1'b0;
  logic     wait_ack, halted, busy;
  cpu_req_t req;
  cpu_rsp_t rsp, r;
  int       n_fail = 0;
  int       check_count = 0;
  always #5 clk_sys = ~clk_sys;
  cpu_bus_model u_cpu (.clk_sys(clk_sys), .rsp(rsp), .req(req));
  data_eeprom_access_controller #(.PROG_LEN(8), .ERASE_LEN(4)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .cpu_req(req), .ext_access(ext_access),
    .protect_on(protect_on), .unprotect_req(unprotect_req),
    .wait_req(wait_req), .halt_req(halt_req), .cpu_rsp(rsp),
    .wait_ack(wait_ack), .halted(halted), .busy(busy));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_cpu.xfer(1'b1, 1'b0, a, d, r);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic f);
    u_cpu.xfer(1'b0, f, a, 8'h00, r);
  endtask : rd
  // never touches the program bit mid cycle
  task automatic wait_done;
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk_sys);
    chk("busy_end", {7'h00, busy}, 8'h00);
  endtask : wait_done
  task automatic t_prog;
    rd(CSR_ADDR, 1'b0);
    chk("csr_rst", r.rdata, 8'h00);
    wr(CSR_ADDR, 8'hFE);
    rd(CSR_ADDR, 1'b0);
    chk("csr_lat", r.rdata, 8'h02);
    rd(16'h1005, 1'b0);
    chk("rd_lat_oe", {7'h00, r.rdata_oe}, 8'h00);
    wr(16'h1005, 8'h5A); // same row throughout
    wr(16'h1005, 8'hF0);
    wr(16'h1006, 8'h33);
    wr(CSR_ADDR, 8'h03);
    rd(CSR_ADDR, 1'b0);
    chk("csr_run", r.rdata, 8'h03);
    wait_done;
    rd(CSR_ADDR, 1'b0);
    chk("csr_done", r.rdata, 8'h00);
    rd(16'h1005, 1'b0);
    chk("and_byte", r.rdata, 8'h50);
    chk("rd_oe", {7'h00, r.rdata_oe}, 8'h01);
    rd(16'h1006, 1'b0);
    chk("byte_6", r.rdata, 8'h33);
    wr(16'h1005, 8'h00);
    rd(16'h1005, 1'b0);
    chk("ign_wr", r.rdata, 8'h50);
    rd(16'h1005, 1'b1);
    chk("fetch_oe", {7'h00, r.rdata_oe}, 8'h00);
  endtask : t_prog
  task automatic t_power;
    wr(CSR_ADDR, 8'h02);
    wr(16'h1010, 8'hAA);
    wr(CSR_ADDR, 8'h03);
    wait_req = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("wait_busy", {7'h00, wait_ack}, 8'h00);
    wait_done;
    repeat (2) @(negedge clk_sys);
    chk("wait_idle", {7'h00, wait_ack}, 8'h01);
    wait_req = 1'b0;
    rd(16'h1010, 1'b0);
    chk("wait_data", r.rdata, 8'hAA);
    wr(CSR_ADDR, 8'h02);
    wr(16'h1011, 8'h00);
    wr(CSR_ADDR, 8'h03);
    halt_req = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("halt_busy", {6'h00, halted, busy}, 8'h02);
    halt_req = 1'b0;
    rd(CSR_ADDR, 1'b0);
    chk("halt_csr", r.rdata, 8'h02);
    wr(CSR_ADDR, 8'h00);
    rd(CSR_ADDR, 1'b0);
    chk("lat_clr", r.rdata, 8'h00);
  endtask : t_power
  task automatic t_protect;
    protect_on = 1'b1;
    ext_access = 1'b1;
    rd(16'h1005, 1'b0);
    chk("prot_oe", {7'h00, r.rdata_oe}, 8'h00);
    ext_access = 1'b0;
    unprotect_req = 1'b1;
    @(negedge clk_sys);
    unprotect_req = 1'b0;
    protect_on = 1'b0;
    repeat (140) @(negedge clk_sys);
    rd(16'h1005, 1'b0);
    chk("wiped", r.rdata, ERASED_BYTE);
  endtask : t_protect
  task automatic wrap_up;
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    t_prog;
    t_power;
    t_protect;
    wrap_up;
  end
  initial begin
    #20000;
    n_fail++;
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
